// *** rtl/dac_margin_gain_cmp_regs.sv ***
// margin-low, gain and channel 1 comparator configuration registers
`default_nettype none
`include "dac_margin_cfg.svh"
module dac_margin_gain_cmp_regs #(
    parameter int CODE_W = `CODE_W
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire dac_margin_pkg::reg_req_t req_i,
    output logic [15:0] rdata_o,
    output logic rvalid_o,
    input wire logic [CODE_W-1:0] fb_code_i,
    input wire logic [CODE_W-1:0] chan1_margin_high_i,
    input wire dac_margin_pkg::cmp_threshold_mode_t comparator_threshold_mode_i,
    output logic [CODE_W-1:0] chan0_margin_low_o,
    output logic [CODE_W-1:0] chan1_margin_low_o,
    output logic [CODE_W-1:0] chan2_margin_low_o,
    output logic [2:0] chan0_gain_o,
    output logic [2:0] chan1_gain_o,
    output logic comparator_enable_o,
    output logic feedback_hiz_disable_o,
    output logic comparator_result_o,
    output logic chan1_output_pin_o,
    output logic chan1_output_pin_oe_n_o,
    output logic chan1_output_pin_od_o
);
    import dac_margin_pkg::*;

    localparam int MF_W = `MARGIN_FIELD_HI - `MARGIN_FIELD_LO + 1;

    logic [MF_W-1:0] chan0_margin_low_code;
    logic [MF_W-1:0] chan1_margin_low_code;
    logic [MF_W-1:0] chan2_margin_low_code;
    logic [2:0] chan0_gain_select;
    logic [2:0] chan1_gain;
    cmp_ctrl_t chan1_cmp_ctrl;
    logic [MF_W-1:0] next_chan0_margin_low_code;
    logic [MF_W-1:0] next_chan1_margin_low_code;
    logic [MF_W-1:0] next_chan2_margin_low_code;
    logic [2:0] next_chan0_gain_select;
    logic [2:0] next_chan1_gain;
    cmp_ctrl_t next_chan1_cmp_ctrl;
    logic [15:0] next_rdata;
    logic next_rvalid;
    logic [MF_W-1:0] wr_margin;
    logic [2:0] wr_gain;

    // only the defined fields are stored, so don't-care bits cannot leak anywhere
    assign wr_margin = req_i.wdata[`MARGIN_FIELD_HI:`MARGIN_FIELD_LO];
    assign wr_gain = req_i.wdata[`GAIN_FIELD_HI:`GAIN_FIELD_LO];

    always_comb begin
        next_chan0_margin_low_code = chan0_margin_low_code;
        next_chan1_margin_low_code = chan1_margin_low_code;
        next_chan2_margin_low_code = chan2_margin_low_code;
        next_chan0_gain_select = chan0_gain_select;
        next_chan1_gain = chan1_gain;
        next_chan1_cmp_ctrl = chan1_cmp_ctrl;
        if (req_i.wr) begin
            case (req_i.addr)
                `OFS_CHAN0_MARGIN_LOW: next_chan0_margin_low_code = wr_margin;
                `OFS_CHAN1_MARGIN_LOW: next_chan1_margin_low_code = wr_margin;
                `OFS_CHAN2_MARGIN_LOW: next_chan2_margin_low_code = wr_margin;
                `OFS_CHAN0_GAIN: next_chan0_gain_select = wr_gain;
                `OFS_CHAN1_GAIN_CMP: begin
                    next_chan1_gain = wr_gain;
                    // enable is taken as written; the host must have powered channel 1 first
                    next_chan1_cmp_ctrl.comparator_enable = req_i.wdata[`CMP_ENABLE_BIT];
                    next_chan1_cmp_ctrl.comparator_invert = req_i.wdata[`CMP_INVERT_BIT];
                    next_chan1_cmp_ctrl.feedback_hiz_disable = req_i.wdata[`CMP_HIZ_DIS_BIT];
                    next_chan1_cmp_ctrl.comparator_pin_route = req_i.wdata[`CMP_ROUTE_BIT];
                    next_chan1_cmp_ctrl.comparator_open_drain = req_i.wdata[`CMP_OD_BIT];
                end
                default: next_chan1_gain = chan1_gain;
            endcase
        end
        next_rvalid = req_i.rd;
        next_rdata = `UNMAPPED_READ;
        if (req_i.rd) begin
            case (req_i.addr)
                `OFS_CHAN0_MARGIN_LOW: next_rdata = {chan0_margin_low_code, 4'h0};
                `OFS_CHAN1_MARGIN_LOW: next_rdata = {chan1_margin_low_code, 4'h0};
                `OFS_CHAN2_MARGIN_LOW: next_rdata = {chan2_margin_low_code, 4'h0};
                `OFS_CHAN0_GAIN: next_rdata = {3'h0, chan0_gain_select, 10'h000};
                `OFS_CHAN1_GAIN_CMP: next_rdata = {3'h0, chan1_gain, 5'h00, chan1_cmp_ctrl};
                default: next_rdata = `UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            chan0_margin_low_code <= `MARGIN_RESET;
            chan1_margin_low_code <= `MARGIN_RESET;
            chan2_margin_low_code <= `MARGIN_RESET;
            chan0_gain_select <= `GAIN_RESET;
            chan1_gain <= `GAIN_RESET;
            chan1_cmp_ctrl <= `CMP_CTRL_RESET;
            rdata_o <= `UNMAPPED_READ;
            rvalid_o <= 1'b0;
        end else begin
            chan0_margin_low_code <= next_chan0_margin_low_code;
            chan1_margin_low_code <= next_chan1_margin_low_code;
            chan2_margin_low_code <= next_chan2_margin_low_code;
            chan0_gain_select <= next_chan0_gain_select;
            chan1_gain <= next_chan1_gain;
            chan1_cmp_ctrl <= next_chan1_cmp_ctrl;
            rdata_o <= next_rdata;
            rvalid_o <= next_rvalid;
        end
    end

    // the two bits below each code are storage only, the converter sees the top ten
    assign chan0_margin_low_o = chan0_margin_low_code[MF_W-1:MF_W-CODE_W];
    assign chan1_margin_low_o = chan1_margin_low_code[MF_W-1:MF_W-CODE_W];
    assign chan2_margin_low_o = chan2_margin_low_code[MF_W-1:MF_W-CODE_W];
    // invalid codes pass through unchanged; the analog side defines nothing for them
    assign chan0_gain_o = chan0_gain_select;
    assign chan1_gain_o = chan1_gain;
    assign comparator_enable_o = chan1_cmp_ctrl.comparator_enable;
    assign feedback_hiz_disable_o = chan1_cmp_ctrl.feedback_hiz_disable;

    cmp_output_stage #(
        .CODE_W(CODE_W)
    ) cmp_output_stage_i (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .ctrl_i(chan1_cmp_ctrl),
        .mode_i(comparator_threshold_mode_i),
        .fb_code_i(fb_code_i),
        .high_code_i(chan1_margin_high_i),
        .low_code_i(chan1_margin_low_o),
        .cmp_result_o(comparator_result_o),
        .pin_o(chan1_output_pin_o),
        .pin_oe_n_o(chan1_output_pin_oe_n_o),
        .pin_od_o(chan1_output_pin_od_o)
    );

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    property p_margin_write;
        req_i.wr && req_i.addr == `OFS_CHAN0_MARGIN_LOW
            |=> chan0_margin_low_o == $past(req_i.wdata[15:6]);
    endproperty
    a_margin_write: assert property (p_margin_write) else $error("channel 0 margin-low not stored");

    property p_reset_zero;
        @(posedge clk_i) disable iff (1'b0)
        !nrst_i |=> chan1_margin_low_o == 10'h000 && chan2_margin_low_o == 10'h000
            && chan0_gain_o == 3'h0 && chan1_gain_o == 3'h0 && !comparator_enable_o;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("register not zero after reset");

    sequence s_gain_write;
        req_i.wr && !req_i.rd && req_i.addr == `OFS_CHAN0_GAIN;
    endsequence
    sequence s_gain_read;
        req_i.rd && !req_i.wr && req_i.addr == `OFS_CHAN0_GAIN;
    endsequence
    property p_gain_readback;
        s_gain_write ##1 s_gain_read
            |=> rvalid_o && rdata_o == {3'h0, $past(req_i.wdata[12:10], 2), 10'h000};
    endproperty
    a_gain_readback: assert property (p_gain_readback) else $error("gain readback wrong");

    property p_cmp_bits;
        req_i.wr && req_i.addr == `OFS_CHAN1_GAIN_CMP
            |=> comparator_enable_o == $past(req_i.wdata[0]) && feedback_hiz_disable_o == $past(req_i.wdata[2]);
    endproperty
    a_cmp_bits: assert property (p_cmp_bits) else $error("comparator control not stored");

    property p_unmapped;
        req_i.rd && !(req_i.addr inside {8'h02, 8'h0e, 8'h0f, 8'h14, 8'h15}) |=> rvalid_o && rdata_o == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    // a back-to-back write and read of 15h returns only the stored fields
    sequence s_cmp_write;
        req_i.wr && !req_i.rd && req_i.addr == `OFS_CHAN1_GAIN_CMP;
    endsequence
    sequence s_cmp_read;
        req_i.rd && !req_i.wr && req_i.addr == `OFS_CHAN1_GAIN_CMP;
    endsequence
    property p_no_dont_care_effect;
        s_cmp_write ##1 s_cmp_read |=> rvalid_o && rdata_o[15:13] == 3'h0 && rdata_o[9:5] == 5'h00
            && rdata_o[12:10] == $past(req_i.wdata[12:10], 2) && rdata_o[4:0] == $past(req_i.wdata[4:0], 2);
    endproperty
    a_no_dont_care_effect: assert property (p_no_dont_care_effect) else $error("don't-care bits read back");

    // the first cycle after reset is skipped, a read taken during reset gets no answer
    property p_read_latency;
        $past(nrst_i) |-> rvalid_o == $past(req_i.rd);
    endproperty
    a_read_latency: assert property (p_read_latency) else $error("read valid not one cycle after request");

    property p_idle_data_zero;
        !rvalid_o |-> rdata_o == `UNMAPPED_READ;
    endproperty
    a_idle_data_zero: assert property (p_idle_data_zero) else $error("read data not cleared between reads");

    // a write to any other address must leave these registers alone
    property p_gain_hold;
        !(req_i.wr && req_i.addr == `OFS_CHAN0_GAIN) |=> $stable(chan0_gain_o);
    endproperty
    a_gain_hold: assert property (p_gain_hold) else $error("channel 0 gain changed without its write");

    property p_margin_hold;
        !(req_i.wr && req_i.addr == `OFS_CHAN2_MARGIN_LOW) |=> $stable(chan2_margin_low_o);
    endproperty
    a_margin_hold: assert property (p_margin_hold) else $error("channel 2 margin-low changed without write");
endmodule : dac_margin_gain_cmp_regs
`default_nettype wire

// *** shared/dac_margin_cfg.svh ***
// offsets, field positions, reset values for the margin, gain and comparator registers
`ifndef DAC_MARGIN_CFG_SVH
`define DAC_MARGIN_CFG_SVH

`define ADDR_W 8
`define DATA_W 16
`define CODE_W 10

`define OFS_CHAN2_MARGIN_LOW 8'h02
`define OFS_CHAN0_MARGIN_LOW 8'h0e
`define OFS_CHAN0_GAIN 8'h0f
`define OFS_CHAN1_MARGIN_LOW 8'h14
`define OFS_CHAN1_GAIN_CMP 8'h15

`define MARGIN_FIELD_HI 15
`define MARGIN_FIELD_LO 4
`define MARGIN_CODE_LO 6
`define GAIN_FIELD_HI 12
`define GAIN_FIELD_LO 10
`define CMP_ENABLE_BIT 0
`define CMP_INVERT_BIT 1
`define CMP_HIZ_DIS_BIT 2
`define CMP_ROUTE_BIT 3
`define CMP_OD_BIT 4

`define MARGIN_RESET 12'h000
`define GAIN_RESET 3'h0
`define CMP_CTRL_RESET 5'h00
`define UNMAPPED_READ 16'h0000

`endif

// *** shared/dac_margin_pkg.sv ***
// types shared by the margin, gain and comparator register bank
`default_nettype none
package dac_margin_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic comparator_open_drain;
        logic comparator_pin_route;
        logic feedback_hiz_disable;
        logic comparator_invert;
        logic comparator_enable;
    } cmp_ctrl_t;

    typedef enum logic [2:0] {
        GAIN_1X_SUPPLY = 3'h1,
        GAIN_1P5X_INT = 3'h2,
        GAIN_2X_INT = 3'h3,
        GAIN_3X_INT = 3'h4,
        GAIN_4X_INT = 3'h5
    } gain_code_t;

    typedef enum logic [1:0] {
        THR_PLAIN = 2'h0,
        THR_HYSTERESIS = 2'h1,
        THR_WINDOW = 2'h2,
        THR_INVALID = 2'h3
    } cmp_threshold_mode_t;
endpackage : dac_margin_pkg
`default_nettype wire

// *** rtl/cmp_output_stage.sv ***
// channel 1 comparator: threshold decision, inversion and output pin drive
`default_nettype none
`include "dac_margin_cfg.svh"
module cmp_output_stage #(
    parameter int CODE_W = `CODE_W
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire dac_margin_pkg::cmp_ctrl_t ctrl_i,
    input wire dac_margin_pkg::cmp_threshold_mode_t mode_i,
    input wire logic [CODE_W-1:0] fb_code_i,
    input wire logic [CODE_W-1:0] high_code_i,
    input wire logic [CODE_W-1:0] low_code_i,
    output logic cmp_result_o,
    output logic pin_o,
    output logic pin_oe_n_o,
    output logic pin_od_o
);
    import dac_margin_pkg::*;

    logic raw;
    logic next_raw;
    logic next_result;
    logic next_pin;
    logic next_oe_n;
    logic next_od;
    logic drive_pin;

    always_comb begin
        next_raw = raw;
        if (!ctrl_i.comparator_enable) begin
            next_raw = 1'b0;
        end else begin
            case (mode_i)
                THR_PLAIN: next_raw = (fb_code_i >= low_code_i);
                THR_HYSTERESIS: begin
                    // between the bounds the last decision holds
                    if (fb_code_i >= high_code_i) begin
                        next_raw = 1'b1;
                    end else if (fb_code_i < low_code_i) begin
                        next_raw = 1'b0;
                    end
                end
                THR_WINDOW: next_raw = (fb_code_i >= low_code_i) && (fb_code_i <= high_code_i);
                default: next_raw = raw;
            endcase
        end
        next_result = next_raw ^ ctrl_i.comparator_invert;
        drive_pin = ctrl_i.comparator_enable && ctrl_i.comparator_pin_route;
        next_od = drive_pin && ctrl_i.comparator_open_drain;
        next_pin = next_result;
        if (!drive_pin) begin
            next_oe_n = 1'b1;
        end else if (next_od) begin
            // open drain only pulls low, a high result releases the pin
            next_oe_n = next_result;
        end else begin
            next_oe_n = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            raw <= 1'b0;
            cmp_result_o <= 1'b0;
            pin_o <= 1'b0;
            pin_oe_n_o <= 1'b1;
            pin_od_o <= 1'b0;
        end else begin
            raw <= next_raw;
            cmp_result_o <= next_result;
            pin_o <= next_pin;
            pin_oe_n_o <= next_oe_n;
            pin_od_o <= next_od;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    property p_invert;
        cmp_result_o == (raw ^ $past(ctrl_i.comparator_invert));
    endproperty
    a_invert: assert property (p_invert) else $error("comparator result not inverted as set");

    property p_route_off;
        !(ctrl_i.comparator_enable && ctrl_i.comparator_pin_route) |=> pin_oe_n_o;
    endproperty
    a_route_off: assert property (p_route_off) else $error("pin driven while not routed");

    property p_od_mode;
        pin_od_o == $past(ctrl_i.comparator_enable && ctrl_i.comparator_pin_route && ctrl_i.comparator_open_drain);
    endproperty
    a_od_mode: assert property (p_od_mode) else $error("open drain mode mismatch");

    property p_od_no_high;
        pin_od_o && pin_o |-> pin_oe_n_o;
    endproperty
    a_od_no_high: assert property (p_od_no_high) else $error("open drain pin driven high");

    sequence s_above_high;
        ctrl_i.comparator_enable && mode_i == THR_HYSTERESIS && fb_code_i >= high_code_i;
    endsequence
    sequence s_hold_between;
        ctrl_i.comparator_enable && mode_i == THR_HYSTERESIS && fb_code_i >= low_code_i
            && fb_code_i < high_code_i;
    endsequence
    property p_hysteresis;
        s_above_high ##1 s_hold_between |=> raw;
    endproperty
    a_hysteresis: assert property (p_hysteresis) else $error("hysteresis lost its state");

    property p_window;
        ctrl_i.comparator_enable && mode_i == THR_WINDOW && fb_code_i > high_code_i |=> !raw;
    endproperty
    a_window: assert property (p_window) else $error("window passed a code above bound");
endmodule : cmp_output_stage
`default_nettype wire

// *** tb/host_model.sv ***
// host-side model: register requests and the channel 1 analog-side levels
`default_nettype none
`include "dac_margin_cfg.svh"
module host_model (
    input wire logic clk_i,
    output var dac_margin_pkg::reg_req_t req_o,
    input wire logic [15:0] rdata_i,
    input wire logic rvalid_i,
    output logic [9:0] fb_code_o,
    output logic [9:0] margin_high_o,
    output var dac_margin_pkg::cmp_threshold_mode_t mode_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import dac_margin_pkg::*;
    initial begin
        req_o = '0;
        fb_code_o = 10'h000;
        margin_high_o = 10'h200;
        mode_o = THR_PLAIN;
    end
    // released lines show the inverse of the last value, so a stale address never looks valid
    task automatic idle(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : idle
    // callers keep gain fields within 000..101
    task automatic write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        idle(a, d);
    endtask : write
    task automatic read(input logic [7:0] a, output logic [15:0] d, output logic v);
        @(posedge clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        idle(a, 16'h0000);
        #1;
        d = rdata_i;
        v = rvalid_i;
    endtask : read
    // write then read the same address with no idle cycle between
    task automatic write_read(input logic [7:0] a, input logic [15:0] w, output logic [15:0] d, output logic v);
        @(posedge clk_i);
        req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: w};
        read(a, d, v);
    endtask : write_read
    // channel 1 is taken as enabled by the host before comparator mode is set
    task automatic set_analog(input logic [9:0] fb, input logic [9:0] hi, input cmp_threshold_mode_t m);
        @(posedge clk_i);
        fb_code_o <= fb;
        margin_high_o <= hi;
        mode_o <= m;
    endtask : set_analog
endmodule : host_model
`default_nettype wire

// *** tb/dac_margin_gain_cmp_regs_tb.sv ***
// self-checking bench for the margin, gain and comparator register bank
`default_nettype none
`include "dac_margin_cfg.svh"
module dac_margin_gain_cmp_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dac_margin_pkg::*;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    reg_req_t req;
    logic [15:0] rdata;
    logic rvalid;
    logic [9:0] fb_code;
    logic [9:0] margin_high;
    logic [9:0] lows [3];
    cmp_threshold_mode_t mode;
    logic [2:0] gain0;
    logic [2:0] gain1;
    logic cmp_en, hiz_dis, result, pin, pin_oe_n, pin_od;
    logic [15:0] gw;
    int fail_count = 0;
    int total_checks = 0;
    logic [7:0] margin_ofs [3] = '{`OFS_CHAN0_MARGIN_LOW, `OFS_CHAN1_MARGIN_LOW, `OFS_CHAN2_MARGIN_LOW};

    host_model host_model_i (.clk_i(clk_i), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid),
        .fb_code_o(fb_code), .margin_high_o(margin_high), .mode_o(mode));
    dac_margin_gain_cmp_regs dac_margin_gain_cmp_regs_i (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req),
        .rdata_o(rdata), .rvalid_o(rvalid), .fb_code_i(fb_code), .chan1_margin_high_i(margin_high),
        .comparator_threshold_mode_i(mode), .chan0_margin_low_o(lows[0]), .chan1_margin_low_o(lows[1]),
        .chan2_margin_low_o(lows[2]), .chan0_gain_o(gain0), .chan1_gain_o(gain1),
        .comparator_enable_o(cmp_en), .feedback_hiz_disable_o(hiz_dis), .comparator_result_o(result),
        .chan1_output_pin_o(pin), .chan1_output_pin_oe_n_o(pin_oe_n), .chan1_output_pin_od_o(pin_od));

    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic v;
        host_model_i.read(a, d, v);
        check("rvalid", {15'h0000, v}, 16'h0001);
        check("rdata", d, exp);
    endtask : rd_chk

    task automatic wr_rd_chk(input logic [7:0] a, input logic [15:0] w, input logic [15:0] exp);
        logic [15:0] d;
        logic v;
        host_model_i.write_read(a, w, d, v);
        check("rvalid", {15'h0000, v}, 16'h0001);
        check("rdata", d, exp);
    endtask : wr_rd_chk

    // expected bits {result, pin, oe_n, od}
    task automatic cmp_case(input logic [15:0] w, input logic [9:0] fb, input cmp_threshold_mode_t m,
                            input logic [3:0] exp);
        logic [3:0] seen;
        host_model_i.write(`OFS_CHAN1_GAIN_CMP, w);
        host_model_i.set_analog(fb, 10'h200, m);
        repeat (3) @(posedge clk_i);
        #1;
        seen = {result, pin, pin_oe_n, pin_od};
        for (int k = 0; k < 4; k++) begin
            check("comparator_pin_bit", {15'h0000, seen[k]}, {15'h0000, exp[k]});
        end
    endtask : cmp_case

    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (5000) @(posedge clk_i);
        fail_count++;
        end_of_test();
    end

    initial begin
        repeat (12) @(posedge clk_i);
        nrst_i <= 1'b1;
        for (int i = 0; i < 3; i++) rd_chk(margin_ofs[i], 16'h0000);
        rd_chk(`OFS_CHAN0_GAIN, 16'h0000);
        rd_chk(`OFS_CHAN1_GAIN_CMP, 16'h0000);
        check("pin_oe_n", {15'h0000, pin_oe_n}, 16'h0001);
        for (int i = 0; i < 3; i++) begin
            host_model_i.write(margin_ofs[i], 16'hffff);
            rd_chk(margin_ofs[i], 16'hfff0);
            check("margin_code", {6'h00, lows[i]}, 16'h03ff);
            host_model_i.write(margin_ofs[i], 16'h804f + (16'(i) << 6));
            rd_chk(margin_ofs[i], 16'h8040 + (16'(i) << 6));
        end
        // distinct codes per channel expose a shared or crossed address decode
        for (int i = 0; i < 3; i++) check("margin_code", {6'h00, lows[i]}, 16'h0201 + 16'(i));
        host_model_i.write(8'h03, 16'hffff);
        rd_chk(8'h03, `UNMAPPED_READ);
        rd_chk(`OFS_CHAN2_MARGIN_LOW, 16'h80c0);
        for (int g = 1; g <= 5; g++) begin
            gw = 16'(g) << 10;
            wr_rd_chk(`OFS_CHAN0_GAIN, 16'he3ff | gw, gw);
            wr_rd_chk(`OFS_CHAN1_GAIN_CMP, 16'he3e0 | gw, gw);
            rd_chk(`OFS_CHAN0_GAIN, gw);
            rd_chk(`OFS_CHAN1_GAIN_CMP, gw);
            check("chan0_gain", {13'h0000, gain0}, 16'(g));
            check("chan1_gain", {13'h0000, gain1}, 16'(g));
            check("comparator_enable", {15'h0000, cmp_en}, 16'h0000);
        end
        host_model_i.write(`OFS_CHAN1_MARGIN_LOW, 16'h4000);
        cmp_case(16'h0009, 10'h150, THR_PLAIN, 4'b1100);
        cmp_case(16'h0009, 10'h100, THR_PLAIN, 4'b1100);
        cmp_case(16'h000b, 10'h150, THR_PLAIN, 4'b0000);
        cmp_case(16'h0001, 10'h150, THR_PLAIN, 4'b1110);
        cmp_case(16'h0019, 10'h150, THR_PLAIN, 4'b1111);
        cmp_case(16'h0019, 10'h050, THR_PLAIN, 4'b0001);
        cmp_case(16'h0011, 10'h150, THR_PLAIN, 4'b1110);
        cmp_case(16'h001a, 10'h150, THR_PLAIN, 4'b1110);
        cmp_case(16'h0009, 10'h250, THR_HYSTERESIS, 4'b1100);
        cmp_case(16'h0009, 10'h180, THR_HYSTERESIS, 4'b1100);
        cmp_case(16'h0009, 10'h050, THR_HYSTERESIS, 4'b0000);
        cmp_case(16'h0009, 10'h180, THR_HYSTERESIS, 4'b0000);
        cmp_case(16'h0009, 10'h180, THR_WINDOW, 4'b1100);
        cmp_case(16'h0009, 10'h250, THR_WINDOW, 4'b0000);
        cmp_case(16'h0009, 10'h050, THR_WINDOW, 4'b0000);
        cmp_case(16'h0009, 10'h180, THR_INVALID, 4'b0000);
        // an invalid mode keeps a set decision even with the level far below the low bound
        cmp_case(16'h0009, 10'h180, THR_WINDOW, 4'b1100);
        cmp_case(16'h0009, 10'h050, THR_INVALID, 4'b1100);
        host_model_i.write(`OFS_CHAN1_GAIN_CMP, 16'h0005);
        repeat (2) @(posedge clk_i);
        #1;
        check("feedback_hiz_disable", {15'h0000, hiz_dis}, 16'h0001);
        host_model_i.write(`OFS_CHAN1_GAIN_CMP, 16'h0009);
        repeat (2) @(posedge clk_i);
        #1;
        check("feedback_hiz_disable", {15'h0000, hiz_dis}, 16'h0000);
        // a second reset in mid-run must bring every register back to zero
        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        rd_chk(`OFS_CHAN1_MARGIN_LOW, 16'h0000);
        rd_chk(`OFS_CHAN1_GAIN_CMP, 16'h0000);
        check("pin_oe_n", {15'h0000, pin_oe_n}, 16'h0001);
        end_of_test();
    end
endmodule : dac_margin_gain_cmp_regs_tb
`default_nettype wire
